// >>> sapmc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sapmc_assertions (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Link
	input wire logic sclk,
	input wire logic csN,
	input wire logic serialResultOut,
	input wire logic serialResultOe
);
	logic sclkPrev_reg;
	logic [4:0] fallCnt_reg;
	logic [2:0] hiCnt_reg;
	logic [2:0] offCnt_reg;
	// ****************************************
	// Helper counters
	// ****************************************
	// Idle counters start saturated, as the line is quiet in reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclkPrev_reg <= 1'h1;
			fallCnt_reg <= 5'h00;
			hiCnt_reg <= 3'h7;
			offCnt_reg <= 3'h7;
		end else begin
			sclkPrev_reg <= sclk;
			fallCnt_reg <= csN ? 5'h00 : fallCnt_reg + 5'(sclkPrev_reg && !sclk);
			hiCnt_reg <= !csN ? 3'h0 : hiCnt_reg + 3'(hiCnt_reg != 3'h7);
			offCnt_reg <= serialResultOe ? 3'h0 : offCnt_reg + 3'(offCnt_reg != 3'h7);
		end
	end
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	oe_frame_on_a: assert property ($fell(csN) |-> ##[1:5] serialResultOe)
		else $error("Output not driven after frame start");
	oe_rise_off_a: assert property ($rose(csN) |-> ##[1:5] !serialResultOe)
		else $error("Output not released after frame end");
	oe_idle_a: assert property (hiCnt_reg >= 3'h5 |-> !serialResultOe)
		else $error("Output driven while idle");
	lead_zero_a: assert property (serialResultOe && !csN && fallCnt_reg <= 5'h03 |-> !serialResultOut)
		else $error("Leading bit not zero");
	full_release_a: assert property ($fell(sclk) && !csN && fallCnt_reg == 5'h0f |-> ##[1:5] !serialResultOe)
		else $error("Output not released after last fall");
	quiet_gap_a: assert property ($fell(csN) |-> offCnt_reg >= 3'h3)
		else $error("Quiet time too short");
	min_falls_a: assert property ($rose(csN) |-> fallCnt_reg >= 5'h02)
		else $error("Frame ended before second fall");
	sclk_idle_a: assert property (hiCnt_reg >= 3'h3 |-> sclk && $stable(sclk))
		else $error("Serial clock moves while idle");
	cover property ($rose(csN) && fallCnt_reg == 5'h10);
	cover property ($rose(csN) && fallCnt_reg == 5'h08);
	cover property ($rose(csN) && fallCnt_reg == 5'h0a);
endmodule
`default_nettype wire

// >>> sapmc_device.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RL1 - Host keeps frame low ten falls
// RL2 - Rise 10..15 falls: stay up, abort
// RL3 - Full result needs sixteen clocks
// RL4 - Frame select may idle high or low
// RL5 - Host waits quiet time after release
// RL6 - Rise after 2nd, before 10th: power down
// RL7 - Power-down aborts and releases output
// RL8 - Analog circuitry off in power-down
// RL9 - Rise before 2nd fall keeps mode
// RL10 - Dummy frame wakes past tenth fall
// RL11 - Powered after 1 us; next valid
// RL12 - Early rise while down: back down
// RL13 - One dummy frame always wakes
// RL14 - Quiet time also after dummy frame
// RL15 - Hold while down; track on edge
// RL16 - Short wake frame after 1 us
// RL17 - Host runs a dummy frame first
// RL18 - Sampler tracks after reset
// RL19 - Lower clock above 320 kSPS
// RL20 - Fall: hold, start, drive output
// RL21 - Sixteenth fall releases output
// RL22 - Four zeros then twelve bits MSB
// RL23 - Quiet time at least 60 ns
// RL24 - Clear count on fall, judge on rise
module sapmc_device
	import sapmc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Link
	sapmc_link_if.dev link,
	// Converter core
	input wire logic [DATA_BITS-1:0] sampleData,
	output logic analogOn,
	output logic samplerHold,
	output logic poweredUp,
	output logic powerDown,
	output logic convStart,
	output logic convAbort,
	output logic convValid
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [1:0] csSync;
		logic csDly;
		logic [1:0] clkSync;
		logic clkDly;
		logic inFrame;
		logic [CNT_W-1:0] edgeCnt;
		logic [FRAME_BITS-1:0] shift;
		logic oe;
		logic hold;
		logic waking;
		sapmc_mode_t mode;
		logic analogOn;
		logic [5:0] puCnt;
		logic poweredUp;
		logic startPulse;
		logic abortPulse;
		logic frameGood;
	} sapmc_dev_t;

	sapmc_dev_t stateReg;
	sapmc_dev_t stateNext;

	localparam sapmc_dev_t DEV_RESET = '{
		csSync: {2{LINE_IDLE}},
		csDly: LINE_IDLE,
		clkSync: {2{LINE_IDLE}},
		clkDly: LINE_IDLE,
		inFrame: 1'h0,
		edgeCnt: '0,
		shift: '0,
		oe: 1'h0,
		hold: 1'h0,
		waking: 1'h0,
		mode: MODE_NORMAL,
		analogOn: 1'h1,
		puCnt: '0,
		poweredUp: 1'h1,
		startPulse: 1'h0,
		abortPulse: 1'h0,
		frameGood: 1'h0
	};

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] n);
		count_up = n + 5'h01;
	endfunction

	function automatic logic [1:0] sync_step(input logic [1:0] stages, input logic pin);
		sync_step = {stages[0], pin};
	endfunction

	function automatic logic fell_now(input logic prevLvl, input logic curLvl);
		fell_now = prevLvl & ~curLvl;
	endfunction

	function automatic logic rose_now(input logic prevLvl, input logic curLvl);
		rose_now = ~prevLvl & curLvl;
	endfunction

	logic csFall;
	logic csRise;
	logic clkFall;
	logic clkRise;

	// Edges are judged on the second stage only; the first stage may be metastable
	assign csFall = fell_now(stateReg.csDly, stateReg.csSync[1]);
	assign csRise = rose_now(stateReg.csDly, stateReg.csSync[1]);
	assign clkFall = fell_now(stateReg.clkDly, stateReg.clkSync[1]);
	assign clkRise = rose_now(stateReg.clkDly, stateReg.clkSync[1]);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		stateNext = stateReg;
		stateNext.startPulse = 1'h0;
		stateNext.abortPulse = 1'h0;
		stateNext.csSync = sync_step(stateReg.csSync, link.csN);
		stateNext.csDly = stateReg.csSync[1];
		stateNext.clkSync = sync_step(stateReg.clkSync, link.sclk);
		stateNext.clkDly = stateReg.clkSync[1];
		if (csFall) begin
			stateNext.inFrame = 1'h1;
			stateNext.edgeCnt = '0; // RL24
			stateNext.shift = {{LEAD_ZEROS{1'h0}}, sampleData}; // RL22
			stateNext.oe = 1'h1; // RL20
			stateNext.hold = 1'h1; // RL20
			stateNext.startPulse = 1'h1; // RL20
			stateNext.frameGood = (stateReg.mode == MODE_NORMAL) && stateReg.poweredUp; // RL11
			if (stateReg.mode == MODE_DOWN) begin
				stateNext.waking = 1'h1; // RL10
				stateNext.analogOn = 1'h1; // RL10
				stateNext.puCnt = '0;
			end
		end else if (csRise && stateReg.inFrame) begin
			stateNext.inFrame = 1'h0;
			stateNext.oe = 1'h0; // RL2 RL7
			stateNext.waking = 1'h0;
			stateNext.abortPulse = (stateReg.edgeCnt != EDGE_FULL); // RL2 RL7
			// Glitch-length frames leave the mode as it was
			if (stateReg.edgeCnt >= EDGE_KEEP) begin
				stateNext.mode = MODE_NORMAL; // RL2 RL24
			end else if (stateReg.edgeCnt >= EDGE_PD_MIN) begin
				stateNext.mode = MODE_DOWN; // RL6 RL24
			end else begin
				stateNext.mode = stateReg.mode; // RL9 RL12
			end
			if (stateNext.mode == MODE_DOWN) begin
				stateNext.analogOn = 1'h0; // RL8 RL12
				stateNext.poweredUp = 1'h0;
				stateNext.puCnt = '0;
				stateNext.hold = 1'h1; // RL15
			end else begin
				stateNext.hold = 1'h0;
			end
		end else if (stateReg.inFrame) begin
			if (clkFall && (stateReg.edgeCnt != EDGE_FULL)) begin
				stateNext.edgeCnt = count_up(stateReg.edgeCnt);
				stateNext.shift = {stateReg.shift[FRAME_BITS-2:0], 1'h0}; // RL22
				if (count_up(stateReg.edgeCnt) == EDGE_FULL) begin
					stateNext.oe = 1'h0; // RL21 RL3
				end
			end
			if (stateReg.waking && (clkFall || clkRise)) begin
				stateNext.hold = 1'h0; // RL15
			end
			if (clkRise && (stateReg.edgeCnt >= EDGE_TRACK)) begin
				stateNext.hold = 1'h0;
			end
		end
		// Power-up timer; one dummy frame of ten falls outlasts it at any legal clock
		// A power-down at the rise wins over a timer expiry in the same cycle
		if (stateReg.analogOn && stateNext.analogOn && !stateReg.poweredUp) begin
			if (stateReg.puCnt == PWRUP_CNT - 6'h01) begin
				stateNext.poweredUp = 1'h1; // RL11 RL13
			end else begin
				stateNext.puCnt = stateReg.puCnt + 6'h01;
			end
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateReg <= DEV_RESET; // RL18
		end else begin
			stateReg <= stateNext;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign link.serialResultOut = stateReg.shift[FRAME_BITS-1];
	assign link.serialResultOe = stateReg.oe;
	assign analogOn = stateReg.analogOn;
	assign samplerHold = stateReg.hold;
	assign poweredUp = stateReg.poweredUp;
	assign powerDown = (stateReg.mode == MODE_DOWN);
	assign convStart = stateReg.startPulse;
	assign convAbort = stateReg.abortPulse;
	assign convValid = stateReg.frameGood;
endmodule
`default_nettype wire

// >>> sapmc_host.sv
`timescale 1ns/1ps
`default_nettype none
module sapmc_host
	import sapmc_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Link
	sapmc_link_if.host link,
	// Command
	input wire logic cmdValid,
	input wire sapmc_cmd_t cmdKind,
	output logic cmdReady,
	// Results
	output logic resValid,
	input wire logic resReady,
	output logic [DATA_BITS-1:0] resData
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		sapmc_hstate_t state;
		logic sclk;
		logic csN;
		logic [5:0] halfCnt;
		logic [5:0] timer;
		logic [CNT_W-1:0] edgeCnt;
		sapmc_cmd_t kind;
		logic [FRAME_BITS-1:0] rx;
		logic [1:0] sdSync;
		logic initDone;
		logic [1:0][DATA_BITS-1:0] bufMem;
		logic wrPtr;
		logic rdPtr;
		logic [1:0] bufCnt;
	} sapmc_host_t;

	sapmc_host_t stateReg;
	sapmc_host_t stateNext;

	localparam sapmc_host_t HOST_RESET = '{
		state: H_IDLE,
		sclk: LINE_IDLE,
		csN: LINE_IDLE,
		halfCnt: '0,
		timer: '0,
		edgeCnt: '0,
		kind: CMD_WAKE,
		rx: '0,
		sdSync: '0,
		initDone: 1'h0,
		bufMem: '0,
		wrPtr: 1'h0,
		rdPtr: 1'h0,
		bufCnt: '0
	};

	function automatic logic [CNT_W-1:0] edge_target(input sapmc_cmd_t k);
		case (k)
			CMD_CONVERT: edge_target = EDGE_FULL; // RL3
			CMD_POWER_DOWN: edge_target = EDGE_PD_HOST; // RL6
			default: edge_target = EDGE_KEEP; // RL10 RL16
		endcase
	endfunction

	logic bufFull;
	logic canStart;
	logic popNow;

	assign bufFull = (stateReg.bufCnt == 2'h2);
	// A conversion waits for buffer room, so a stalled reader never loses a word
	assign canStart = (stateReg.state == H_IDLE) && stateReg.initDone &&
		((cmdKind != CMD_CONVERT) || !bufFull);
	assign popNow = resValid && resReady;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		stateNext = stateReg;
		stateNext.sdSync = {stateReg.sdSync[0], link.serialResultLine};
		if (stateReg.timer != PWRUP_CNT) begin
			stateNext.timer = stateReg.timer + 6'h01;
		end
		if (popNow) begin
			stateNext.rdPtr = ~stateReg.rdPtr;
			stateNext.bufCnt = stateReg.bufCnt - 2'h1;
		end
		case (stateReg.state)
			H_IDLE: begin
				// Frame select idles high between frames
				stateNext.csN = 1'h1; // RL4
				stateNext.sclk = 1'h1;
				if (!stateReg.initDone || (cmdValid && canStart)) begin
					stateNext.kind = stateReg.initDone ? cmdKind : CMD_WAKE; // RL17
					stateNext.csN = 1'h0;
					stateNext.edgeCnt = '0;
					stateNext.halfCnt = '0;
					stateNext.timer = '0;
					stateNext.state = H_SETUP;
				end
			end
			H_SETUP: begin
				stateNext.halfCnt = stateReg.halfCnt + 6'h01;
				if (stateReg.halfCnt == SCLK_HALF - 6'h01) begin
					stateNext.halfCnt = '0;
					stateNext.state = H_CLK;
				end
			end
			H_CLK: begin
				stateNext.halfCnt = stateReg.halfCnt + 6'h01;
				// A slow fixed clock trades throughput for lower power
				if (stateReg.halfCnt == SCLK_HALF - 6'h01) begin // RL19
					stateNext.halfCnt = '0;
					stateNext.sclk = ~stateReg.sclk;
					if (stateReg.sclk) begin
						// Bit n-1 is read as fall n is made
						stateNext.rx = {stateReg.rx[FRAME_BITS-2:0], stateReg.sdSync[1]};
						stateNext.edgeCnt = stateReg.edgeCnt + 5'h01;
						if (stateReg.edgeCnt + 5'h01 == edge_target(stateReg.kind)) begin
							stateNext.state = H_END; // RL1
						end
					end
				end
			end
			H_END: begin
				if (stateReg.halfCnt != SCLK_HALF) begin
					stateNext.halfCnt = stateReg.halfCnt + 6'h01;
				end
				if ((stateReg.halfCnt == SCLK_HALF) &&
					((stateReg.kind != CMD_WAKE) || (stateReg.timer == PWRUP_CNT))) begin
					stateNext.csN = 1'h1; // RL16
					stateNext.sclk = 1'h1;
					stateNext.halfCnt = '0;
					stateNext.state = H_QUIET;
					if (stateReg.kind == CMD_CONVERT) begin
						stateNext.bufMem[stateReg.wrPtr] = stateReg.rx[DATA_BITS-1:0];
						stateNext.wrPtr = ~stateReg.wrPtr;
						stateNext.bufCnt = stateNext.bufCnt + 2'h1;
					end
				end
			end
			H_QUIET: begin
				// Covers the device's release lag plus the quiet time
				stateNext.halfCnt = stateReg.halfCnt + 6'h01;
				if (stateReg.halfCnt == QUIET_WAIT - 6'h01) begin
					stateNext.initDone = 1'h1;
					stateNext.state = H_IDLE; // RL5 RL14 RL23
				end
			end
			default: begin
				stateNext.state = H_IDLE;
			end
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stateReg <= HOST_RESET;
		end else begin
			stateReg <= stateNext;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign link.sclk = stateReg.sclk;
	assign link.csN = stateReg.csN;
	assign cmdReady = canStart;
	assign resValid = (stateReg.bufCnt != 2'h0);
	assign resData = stateReg.bufMem[stateReg.rdPtr];
endmodule
`default_nettype wire

// >>> sapmc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sapmc_link_if;
	logic sclk;
	logic csN;
	logic serialResultOut;
	logic serialResultOe;
	logic serialResultLine;
	// Released line is read as high, as with a weak pull-up
	assign serialResultLine = serialResultOe ? serialResultOut : 1'h1;
	modport dev (
		input sclk,
		input csN,
		output serialResultOut,
		output serialResultOe
	);
	modport host (
		output sclk,
		output csN,
		input serialResultLine
	);
endinterface
`default_nettype wire

// >>> sapmc_pkg.sv
package sapmc_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int PWRUP_TIME_NS = 1000;
	localparam int PWRUP_CYC = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int QUIET_TIME_NS = 60;
	localparam int QUIET_CYC = (QUIET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RELEASE_TO_HIZ_DELAY_NS = 35;
	// Two synchroniser stages plus the output register
	localparam int HIZ_LAG_CYC = 3;
	localparam logic [5:0] PWRUP_CNT = 6'(PWRUP_CYC);
	localparam logic [5:0] QUIET_WAIT = 6'(QUIET_CYC + HIZ_LAG_CYC);
	localparam logic [5:0] SCLK_HALF = 6'h06;
	// ****************************************
	// Frame layout
	// ****************************************
	localparam int FRAME_BITS = 16;
	localparam int LEAD_ZEROS = 4;
	localparam int DATA_BITS = 12;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] EDGE_PD_MIN = 5'h02;
	localparam logic [CNT_W-1:0] EDGE_KEEP = 5'h0a;
	localparam logic [CNT_W-1:0] EDGE_TRACK = 5'h0d;
	localparam logic [CNT_W-1:0] EDGE_FULL = 5'h10;
	localparam logic [CNT_W-1:0] EDGE_PD_HOST = 5'h08;
	localparam logic LINE_IDLE = 1'h1;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic {MODE_NORMAL, MODE_DOWN} sapmc_mode_t;
	typedef enum logic [1:0] {CMD_CONVERT, CMD_POWER_DOWN, CMD_WAKE} sapmc_cmd_t;
	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_CLK, H_END, H_QUIET} sapmc_hstate_t;
endpackage

// >>> tb_serial_adc_power_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_fail++; \
	$display("Error %s expected %0h seen %0h", nm, exp, got); end end
module tb_serial_adc_power_mode_control;
	import sapmc_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic core_clk = 1'h0;
	logic rst_n = 1'h0;
	logic cmdValid = 1'h0;
	sapmc_cmd_t cmdKind = CMD_CONVERT;
	logic resReady = 1'h0;
	logic [DATA_BITS-1:0] sampleData = 12'h000;
	logic cmdReady, resValid, analogOn, samplerHold, poweredUp, powerDown, convValid, convAbort;
	logic powerDown2, convStart;
	logic [DATA_BITS-1:0] resData;
	int n_fail = 0;
	int checks = 0;
	int nAbort = 0;
	int nStart = 0;
	sapmc_link_if link ();
	sapmc_link_if link2 ();
	always #12.5 core_clk = ~core_clk;
	always @(negedge core_clk) if (convAbort === 1'h1) nAbort++;
	always @(negedge core_clk) if (convStart === 1'h1) nStart++;
	sapmc_device i_sapmc_device (.core_clk(core_clk), .rst_n(rst_n), .link(link),
		.sampleData(sampleData), .analogOn(analogOn), .samplerHold(samplerHold),
		.poweredUp(poweredUp), .powerDown(powerDown), .convStart(convStart), .convAbort(convAbort),
		.convValid(convValid));
	// Second device faces the bench directly, so frames of any length can be sent
	sapmc_device i_sapmc_device2 (.core_clk(core_clk), .rst_n(rst_n), .link(link2),
		.sampleData(12'h000), .analogOn(), .samplerHold(), .poweredUp(), .powerDown(powerDown2),
		.convStart(), .convAbort(), .convValid());
	sapmc_host i_sapmc_host (.core_clk(core_clk), .rst_n(rst_n), .link(link), .cmdValid(cmdValid),
		.cmdKind(cmdKind), .cmdReady(cmdReady), .resValid(resValid), .resReady(resReady),
		.resData(resData));
	sapmc_assertions i_sapmc_assertions (.core_clk(core_clk), .rst_n(rst_n), .sclk(link.sclk),
		.csN(link.csN), .serialResultOut(link.serialResultOut),
		.serialResultOe(link.serialResultOe));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic final_report();
		if (n_fail == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		while (cmdReady !== 1'h1 && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		`CHK("cmdReady", 1'h1, cmdReady)
	endtask
	// Capture happens three cycles after the fall, so the hold covers it
	task automatic send(input sapmc_cmd_t kind);
		cmdKind = kind;
		cmdValid = 1'h1;
		wait_ready();
		@(negedge core_clk);
		cmdValid = 1'h0;
		repeat (8) @(negedge core_clk);
	endtask
	task automatic pop(input logic [DATA_BITS-1:0] exp);
		int n;
		n = 0;
		while (resValid !== 1'h1 && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		`CHK("resData", exp, resData)
		resReady = 1'h1;
		@(negedge core_clk);
		resReady = 1'h0;
	endtask
	task automatic frame(input int falls);
		link2.csN = 1'h0;
		repeat (6) @(negedge core_clk);
		for (int i = 0; i < falls; i++) begin
			link2.sclk = 1'h0;
			repeat (6) @(negedge core_clk);
			link2.sclk = 1'h1;
			repeat (6) @(negedge core_clk);
		end
		link2.csN = 1'h1;
		repeat (8) @(negedge core_clk);
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		link2.csN = 1'h1;
		link2.sclk = 1'h1;
		repeat (8) @(negedge core_clk);
		`CHK("samplerHold", 1'h0, samplerHold)
		rst_n = 1'h1;
		frame(1);
		`CHK("powerDown2", 1'h0, powerDown2)
		frame(2);
		`CHK("powerDown2", 1'h1, powerDown2)
		frame(9);
		`CHK("powerDown2", 1'h1, powerDown2)
		frame(1);
		`CHK("powerDown2", 1'h1, powerDown2)
		frame(10);
		`CHK("powerDown2", 1'h0, powerDown2)
		wait_ready();
		`CHK("powerDown", 1'h0, powerDown)
		`CHK("nAbort", 1, nAbort)
		sampleData = 12'ha5c;
		send(CMD_CONVERT);
		sampleData = 12'h801;
		send(CMD_CONVERT);
		// Reader stalls: a third conversion must wait for room
		sampleData = 12'hfff;
		cmdValid = 1'h1;
		repeat (300) @(negedge core_clk);
		`CHK("cmdReady", 1'h0, cmdReady)
		pop(12'ha5c);
		send(CMD_CONVERT);
		pop(12'h801);
		pop(12'hfff);
		`CHK("convValid", 1'h1, convValid)
		`CHK("nAbort", 1, nAbort)
		for (int i = 0; i < 2; i++) begin
			send(CMD_POWER_DOWN);
			wait_ready();
			`CHK("powerDown", 1'h1, powerDown)
			`CHK("analogOn", 1'h0, analogOn)
			`CHK("poweredUp", 1'h0, poweredUp)
			`CHK("samplerHold", 1'h1, samplerHold)
			if (i == 0) `CHK("nAbort", 2, nAbort)
		end
		`CHK("serialResultLine", 1'h1, link.serialResultLine)
		`CHK("sclk", 1'h1, link.sclk)
		send(CMD_WAKE);
		wait_ready();
		`CHK("powerDown", 1'h0, powerDown)
		`CHK("poweredUp", 1'h1, poweredUp)
		`CHK("samplerHold", 1'h0, samplerHold)
		`CHK("convValid", 1'h0, convValid)
		sampleData = 12'h3c6;
		send(CMD_CONVERT);
		pop(12'h3c6);
		`CHK("convValid", 1'h1, convValid)
		`CHK("nStart", 8, nStart)
		final_report();
	end
	// Whole run is under two thousand cycles
	initial begin
		repeat (10000) @(posedge core_clk);
		n_fail++;
		final_report();
	end
endmodule
`default_nettype wire
